/* File: rtl/lcdp_pkg.sv */
// package: constants and types for the display bus port
// Function
// [R1] strap picks enable-clock or split-strobe bus
// [R2] port selected only with low_n low, high high
// [R3] data lines released whenever port is deselected; host end keeps driving them after a serial transfer
// [R4] cmd_data_sel high is data, low is command
// [R5] split-strobe: drive data while read strobe low
// [R6] enable-clock: shared strobe is active-high enable
// [R7] split-strobe: capture data at write strobe rise
// [R8] enable-clock: direction high reads, low writes
// [R9] hard_init_n low restores all settings
// [R10] serial: bit 7 data, bit 6 clock
// [R11] serial: host ties lower six lines fixed
// [R12] duty straps give 1/33, 1/49, 1/65
// [R13] normal polarity: memory one lights pixel
// [R14] memory is 65 rows by 132 columns
// [R15] memory access timed by strobes only
// [R16] bias command selects 1/4 through 1/9
// [R17] decode data/status read, data/command write
// [R18] first read after address or write stale
// [R19] serial msb first, byte at eighth rise
// [R20] deselected serial state held reset; no reads
`default_nettype none

package lcdp_pkg;
    localparam int unsigned CLK_MHZ    = 50;
    localparam int unsigned T_SETUP_NS = 80;
    localparam int unsigned T_PULSE_NS = 160;
    localparam int unsigned T_HOLD_NS  = 80;
    // least times: round up to whole cycles
    localparam int unsigned SETUP_CYC  = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PULSE_CYC  = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned HOLD_CYC   = (T_HOLD_NS * CLK_MHZ + 999) / 1000;

    localparam int unsigned MEM_ROWS  = 65;
    localparam int unsigned MEM_COLS  = 132;
    localparam int unsigned MEM_PAGES = (MEM_ROWS + 7) / 8;

    localparam logic [3:0] CMD_PAGE_HI = 4'hB;
    localparam logic [3:0] CMD_COLH_HI = 4'h1;
    localparam logic [3:0] CMD_COLL_HI = 4'h0;
    localparam logic [4:0] CMD_BIAS_HI = 5'h06;
    localparam logic [7:0] CMD_NORMAL  = 8'hA6;
    localparam logic [7:0] CMD_REVERSE = 8'hA7;
    localparam logic [2:0] BIAS_MAX    = 3'h5;
    localparam logic [2:0] BIAS_RST    = 3'h0;
    localparam int unsigned STAT_REV_BIT = 5;
    localparam logic [7:0] LAST_PAGE_MASK = 8'h01;

    localparam logic [6:0] DUTY_33 = 7'h21;
    localparam logic [6:0] DUTY_49 = 7'h31;
    localparam logic [6:0] DUTY_65 = 7'h41;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_CFG  = 8'h08;
    localparam int unsigned CTRL_CD_BIT   = 8;
    localparam int unsigned CTRL_RD_BIT   = 9;
    localparam int unsigned STAT_BUSY_BIT = 8;
    localparam int unsigned STAT_REF_BIT  = 9;
    localparam int unsigned CFG_W         = 5;
    localparam logic [4:0]  CFG_RST       = 5'h0A;

    typedef enum {HS_IDLE, HS_SETUP, HS_PULSE, HS_HOLD, HS_SLO, HS_SHI} lcdp_hst_t;
endpackage

`default_nettype wire

/* File: rtl/lcdp_if.sv */
// interface: pins between host end and device end
`default_nettype none

interface lcdp_if;
    logic       select_low_n;
    logic       select_high;
    logic       cmd_data_sel;
    logic       read_strobe;
    logic       write_strobe;
    logic       hard_init_n;
    logic       bus_family_sel;
    logic       parallel_sel;
    logic       drive_ratio_sel_lo;
    logic       drive_ratio_sel_hi;
    logic [7:0] host_d;
    logic       host_oe;
    logic [7:0] dev_d;
    logic       dev_oe;
    logic [7:0] d_line;

    // undriven lines float high, as with a weak pull-up
    assign d_line = dev_oe ? dev_d : (host_oe ? host_d : 8'hFF);

    modport dev (
        input  select_low_n, select_high, cmd_data_sel, read_strobe, write_strobe,
        input  hard_init_n, bus_family_sel, parallel_sel,
        input  drive_ratio_sel_lo, drive_ratio_sel_hi, d_line,
        output dev_d, dev_oe
    );
    modport host (
        output select_low_n, select_high, cmd_data_sel, read_strobe, write_strobe,
        output hard_init_n, bus_family_sel, parallel_sel,
        output drive_ratio_sel_lo, drive_ratio_sel_hi, host_d, host_oe,
        input  d_line
    );
endinterface

`default_nettype wire

/* File: rtl/lcdp_sync.sv */
// two-flop synchroniser for pin inputs
`default_nettype none

module lcdp_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         MCLK_I,
    input  wire logic         SYS_RST_I,
    input  wire logic [W-1:0] D_I,
    output logic      [W-1:0] Q_O
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } lcdp_sync_st_t;

    lcdp_sync_st_t q, d;

    if (W < 1) begin : g_chk
        $error("lcdp_sync: W must be at least 1");
    end

    // first stage feeds only the second
    always_comb begin
        d    = q;
        d.s1 = D_I;
        d.s2 = q.s1;
    end

    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign Q_O = q.s2;
endmodule

`default_nettype wire

/* File: rtl/lcdp_dev.sv */
// device end: bus port, command decode and display memory
`default_nettype none

module lcdp_dev #(
    parameter int unsigned COLS  = lcdp_pkg::MEM_COLS,
    parameter int unsigned PAGES = lcdp_pkg::MEM_PAGES
) (
    input  wire logic       MCLK_I,
    input  wire logic       SYS_RST_I,
    lcdp_if.dev             BUS,
    input  wire logic [6:0] PIX_ROW_I,
    input  wire logic [7:0] PIX_COL_I,
    output logic            PIX_O,
    output logic [6:0]      DUTY_ROWS_O,
    output logic [2:0]      BIAS_SEL_O,
    output logic            REVERSE_O
);
    import lcdp_pkg::*;

    // ==========================================================
    // parameter check
    if (COLS > 256 || PAGES > 16 || COLS < 1 || PAGES < 1) begin : g_chk
        $error("lcdp_dev: COLS or PAGES out of range");
    end

    // ==========================================================
    // pin synchronisers
    logic [17:0] pin_s;
    logic        s_low_n;
    logic        s_high;
    logic        s_cd;
    logic        s_rstb;
    logic        s_wstb;
    logic        s_init_n;
    logic        s_family;
    logic        s_par;
    logic        s_duty_lo;
    logic        s_duty_hi;
    logic [7:0]  s_d;

    lcdp_sync #(.W(18)) u_sync (
        .MCLK_I    (MCLK_I),
        .SYS_RST_I (SYS_RST_I),
        .D_I       ({BUS.select_low_n, BUS.select_high, BUS.cmd_data_sel,
                     BUS.read_strobe, BUS.write_strobe, BUS.hard_init_n,
                     BUS.bus_family_sel, BUS.parallel_sel,
                     BUS.drive_ratio_sel_lo, BUS.drive_ratio_sel_hi, BUS.d_line}),
        .Q_O       (pin_s)
    );

    assign {s_low_n, s_high, s_cd, s_rstb, s_wstb, s_init_n,
            s_family, s_par, s_duty_lo, s_duty_hi, s_d} = pin_s;

    // ==========================================================
    // state
    typedef struct packed {
        logic       rd_act;
        logic       wr_act;
        logic       sclk;
        logic [3:0] page;
        logic [7:0] col;
        logic [7:0] holder;
        logic       reverse;
        logic [2:0] bias;
        logic [7:0] shift;
        logic [2:0] cnt;
        logic [7:0] dout;
        logic       oe;
        logic       pix;
        logic [6:0] duty;
    } lcdp_dev_st_t;

    localparam lcdp_dev_st_t ST_RST = '{
        rd_act: 1'b0, wr_act: 1'b0, sclk: 1'b0, page: 4'h0, col: 8'h00,
        holder: 8'h00, reverse: 1'b0, bias: BIAS_RST, shift: 8'h00,
        cnt: 3'h0, dout: 8'h00, oe: 1'b0, pix: 1'b0, duty: DUTY_33};

    localparam int unsigned DEPTH = PAGES * COLS;
    localparam int unsigned AW    = $clog2(DEPTH);

    lcdp_dev_st_t q, d;
    logic [7:0]   mem [DEPTH];
    logic         we;
    logic [AW-1:0] waddr;
    logic [7:0]   wdata;
    logic [AW-1:0] cur_addr;
    logic [AW-1:0] pix_addr;
    logic         sel;
    logic         rd_now;
    logic         wr_now;
    logic         byte_v;
    logic         byte_cd;
    logic [7:0]   byte_d;

    assign cur_addr = AW'(q.page * COLS + q.col);
    assign pix_addr = AW'(PIX_ROW_I[6:3] * COLS + PIX_COL_I);

    // ==========================================================
    // next state
    always_comb begin
        d       = q;
        we      = 1'b0;
        waddr   = cur_addr;
        wdata   = 8'h00;
        byte_v  = 1'b0;
        byte_cd = s_cd;
        byte_d  = s_d;

        sel = ~s_low_n & s_high;                                     // see [R2]
        // enable clock high qualifies, direction picks read or write
        rd_now = s_family ? (s_rstb & s_wstb) : ~s_rstb;             // see [R1] see [R6] see [R8]
        wr_now = s_family ? (s_rstb & ~s_wstb) : ~s_wstb;            // see [R1] see [R6] see [R8]
        d.rd_act = rd_now & sel & s_par;
        d.wr_act = wr_now & sel & s_par;
        d.oe     = d.rd_act;                                         // see [R3] see [R5]
        d.dout   = s_cd ? q.holder : 8'h00;                          // see [R17]
        d.dout[STAT_REV_BIT] = s_cd ? q.holder[STAT_REV_BIT] : q.reverse;

        // read ends: holder takes current cell, so first read is stale
        if (q.rd_act && !d.rd_act && s_cd) begin                     // see [R18]
            d.holder = mem[cur_addr];
            if (q.col < 8'(COLS - 1)) begin
                d.col = q.col + 8'h01;
            end
        end

        // write strobe rise (or enable fall) latches the bus
        if (q.wr_act && !d.wr_act) begin                             // see [R7]
            byte_v = 1'b1;
        end

        // serial: bit 7 data, bit 6 clock; reads never served
        d.sclk = s_d[6];                                             // see [R10]
        if (!s_par) begin
            if (!sel) begin
                d.shift = 8'h00;                                     // see [R20]
                d.cnt   = 3'h0;
            end else if (s_d[6] && !q.sclk) begin
                d.shift = {q.shift[6:0], s_d[7]};                    // see [R19]
                d.cnt   = q.cnt + 3'h1;
                if (q.cnt == 3'h7) begin
                    byte_v = 1'b1;
                    byte_d = {q.shift[6:0], s_d[7]};
                end
            end
        end

        if (byte_v) begin
            if (byte_cd) begin                                       // see [R4] see [R17]
                // no display clock: the strobe alone stores the byte
                we    = 1'b1;                                        // see [R15]
                wdata = (q.page == 4'(PAGES - 1)) ? (byte_d & LAST_PAGE_MASK) : byte_d;
                if (q.col < 8'(COLS - 1)) begin
                    d.col = q.col + 8'h01;
                end
            end else if (byte_d[7:4] == CMD_PAGE_HI) begin
                if (byte_d[3:0] < 4'(PAGES)) begin
                    d.page = byte_d[3:0];
                end
            end else if (byte_d[7:4] == CMD_COLH_HI) begin
                if ({byte_d[3:0], q.col[3:0]} < 8'(COLS)) begin
                    d.col = {byte_d[3:0], q.col[3:0]};
                end
            end else if (byte_d[7:4] == CMD_COLL_HI) begin
                d.col = {q.col[7:4], byte_d[3:0]};
            end else if (byte_d[7:3] == CMD_BIAS_HI) begin
                if (byte_d[2:0] <= BIAS_MAX) begin
                    d.bias = byte_d[2:0];                            // see [R16]
                end
            end else if (byte_d == CMD_NORMAL) begin
                d.reverse = 1'b0;
            end else if (byte_d == CMD_REVERSE) begin
                d.reverse = 1'b1;
            end
        end

        // duty straps, upper one wins
        if (s_duty_hi) begin                                         // see [R12]
            d.duty = DUTY_65;
        end else if (s_duty_lo) begin
            d.duty = DUTY_49;
        end else begin
            d.duty = DUTY_33;
        end

        // memory one lights the pixel unless reversed
        d.pix = mem[pix_addr][PIX_ROW_I[2:0]] ^ q.reverse;           // see [R13] see [R14]

        // level reset: held low keeps settings at initial values
        if (!s_init_n) begin                                         // see [R9]
            d.page    = ST_RST.page;
            d.col     = ST_RST.col;
            d.bias    = ST_RST.bias;
            d.reverse = ST_RST.reverse;
            d.shift   = ST_RST.shift;
            d.cnt     = ST_RST.cnt;
            we        = 1'b0;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // memory content is not reset, as on real panels
    always_ff @(posedge MCLK_I) begin
        if (we) begin                                                // see [R14]
            mem[waddr] <= wdata;
        end
    end

    assign BUS.dev_d   = q.dout;
    assign BUS.dev_oe  = q.oe;
    assign PIX_O       = q.pix;
    assign DUTY_ROWS_O = q.duty;
    assign BIAS_SEL_O  = q.bias;
    assign REVERSE_O   = q.reverse;
endmodule

`default_nettype wire

/* File: rtl/lcdp_host.sv */
// host end: APB registers driving the display bus pins
`default_nettype none

module lcdp_host (
    input  wire logic        MCLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    lcdp_if.host             BUS
);
    import lcdp_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        lcdp_hst_t  st;
        logic [7:0] cnt;
        logic [2:0] bitn;
        logic [7:0] tx;
        logic       rd;
        logic [7:0] rdata;
        logic       busy;
        logic       refused;
        logic [CFG_W-1:0] cfg;
        logic       pready;
        logic       perr;
        logic [31:0] prdata;
        logic       sel;
        logic       cd;
        logic       rstb;
        logic       wstb;
        logic [7:0] dout;
        logic       oe;
    } lcdp_host_st_t;

    lcdp_host_st_t q, d;
    logic [7:0]    d_s;
    logic          fam;
    logic          par;

    lcdp_sync #(.W(8)) u_sync (
        .MCLK_I    (MCLK_I),
        .SYS_RST_I (SYS_RST_I),
        .D_I       (BUS.d_line),
        .Q_O       (d_s)
    );

    assign fam = q.cfg[0];
    assign par = q.cfg[1];

    // ==========================================================
    // next state
    always_comb begin
        d = q;
        // apb: answer in the cycle after setup
        d.pready = PSEL_I & ~PENABLE_I;
        if (PSEL_I && !PENABLE_I) begin
            d.perr   = (PADDR_I != REG_CTRL) && (PADDR_I != REG_STAT) &&
                       (PADDR_I != REG_CFG);
            d.prdata = 32'h0;
            if (PADDR_I == REG_STAT) begin
                d.prdata[7:0]          = q.rdata;
                d.prdata[STAT_BUSY_BIT] = q.busy;
                d.prdata[STAT_REF_BIT]  = q.refused;
            end else if (PADDR_I == REG_CFG) begin
                d.prdata[CFG_W-1:0] = q.cfg;
            end
        end

        if (PSEL_I && PENABLE_I && q.pready && PWRITE_I) begin
            if (PADDR_I == REG_CFG && !q.busy) begin
                d.cfg = PWDATA_I[CFG_W-1:0];
            end else if (PADDR_I == REG_CTRL) begin
                // busy, or a read asked of the serial link, is refused
                if (q.busy || (!par && PWDATA_I[CTRL_RD_BIT])) begin  // see [R20]
                    d.refused = 1'b1;
                end else begin
                    d.refused = 1'b0;
                    d.busy    = 1'b1;
                    d.tx      = PWDATA_I[7:0];
                    d.cd      = PWDATA_I[CTRL_CD_BIT];                // see [R4]
                    d.rd      = PWDATA_I[CTRL_RD_BIT];
                    d.sel     = 1'b1;                                 // see [R2]
                    d.bitn    = 3'h0;
                    d.cnt     = 8'(SETUP_CYC);
                    d.st      = par ? HS_SETUP : HS_SLO;
                    // serial drives all lines, lower six held low
                    d.oe      = ~par | ~PWDATA_I[CTRL_RD_BIT];       // see [R11]
                    d.dout    = par ? PWDATA_I[7:0] : {PWDATA_I[7], 7'h00};
                    d.wstb    = fam ? PWDATA_I[CTRL_RD_BIT] : 1'b1;   // see [R8]
                end
            end
        end

        if (q.st != HS_IDLE && q.cnt != 8'h00) begin
            d.cnt = q.cnt - 8'h01;
        end

        case (q.st)
            HS_IDLE: begin
            end
            HS_SETUP: begin
                if (q.cnt == 8'h01) begin
                    d.st  = HS_PULSE;
                    d.cnt = 8'(PULSE_CYC);
                    if (fam) begin
                        d.rstb = 1'b1;                                // see [R6]
                    end else if (q.rd) begin
                        d.rstb = 1'b0;                                // see [R5]
                    end else begin
                        d.wstb = 1'b0;                                // see [R7]
                    end
                end
            end
            HS_PULSE: begin
                if (q.cnt == 8'h01) begin
                    if (q.rd) begin
                        d.rdata = d_s;                                // see [R17]
                    end
                    d.st   = HS_HOLD;
                    d.cnt  = 8'(HOLD_CYC);
                    d.rstb = ~fam;
                    d.wstb = fam ? q.wstb : 1'b1;
                end
            end
            HS_SLO: begin
                if (q.cnt == 8'h01) begin
                    d.st      = HS_SHI;
                    d.cnt     = 8'(PULSE_CYC);
                    d.dout[6] = 1'b1;                                 // see [R10] see [R19]
                end
            end
            HS_SHI: begin
                if (q.cnt == 8'h01) begin
                    d.dout[6] = 1'b0;
                    d.bitn    = q.bitn + 3'h1;
                    d.cnt     = 8'(SETUP_CYC);
                    d.st      = (q.bitn == 3'h7) ? HS_HOLD : HS_SLO;
                    d.dout[7] = q.tx[3'h6 - q.bitn];
                end
            end
            HS_HOLD: begin
                if (q.cnt == 8'h01) begin
                    d.st   = HS_IDLE;
                    d.sel  = 1'b0;                                    // see [R3]
                    d.oe   = ~par;
                    d.busy = 1'b0;
                end
            end
            default: begin
                d.st = HS_IDLE;
            end
        endcase
        // idle levels follow a new bus style at once; the direction set up
        // for a transfer must not be overwritten in its first cycle
        if (!d.busy) begin
            d.rstb = ~d.cfg[0];
            d.wstb = ~d.cfg[0];
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            q      <= '0;
            q.st   <= HS_IDLE;
            q.cfg  <= CFG_RST;
            q.rstb <= 1'b1;
            q.wstb <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign PRDATA_O               = q.prdata;
    assign PREADY_O               = q.pready;
    assign PSLVERR_O              = q.perr;
    assign BUS.select_low_n       = ~q.sel;
    assign BUS.select_high        = q.sel;
    assign BUS.cmd_data_sel       = q.cd;
    assign BUS.read_strobe        = q.rstb;
    assign BUS.write_strobe       = q.wstb;
    assign BUS.host_d             = q.dout;
    assign BUS.host_oe            = q.oe;
    assign BUS.bus_family_sel     = q.cfg[0];
    assign BUS.parallel_sel       = q.cfg[1];
    assign BUS.drive_ratio_sel_lo = q.cfg[2];
    assign BUS.drive_ratio_sel_hi = q.cfg[3];
    assign BUS.hard_init_n        = ~q.cfg[4];
endmodule

`default_nettype wire

/* File: tb/lcdp_asserts.sv */
// checker: pin-level properties of the display bus link
`default_nettype none

module lcdp_asserts (
    input wire logic       MCLK_I,
    input wire logic       SYS_RST_I,
    input wire logic       select_low_n,
    input wire logic       select_high,
    input wire logic       read_strobe,
    input wire logic       write_strobe,
    input wire logic       bus_family_sel,
    input wire logic       parallel_sel,
    input wire logic [7:0] host_d,
    input wire logic       host_oe,
    input wire logic       dev_oe
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (SYS_RST_I);
    wire logic sel = !select_low_n && select_high;
    // ==========
    // device drive
    // deselect reaches dev_oe through three flops (two synchroniser, one output), hence four cycles
    a_desel_release: assert property (!sel [*4] |-> !dev_oe)
        else $error("data bus driven while deselected");
    a_oe_on_read: assert property ($rose(dev_oe) |-> sel &&
        parallel_sel && (bus_family_sel ? read_strobe && write_strobe : !read_strobe))
        else $error("device drive without a read cycle");
    a_oe_read_end: assert property (!bus_family_sel && $rose(read_strobe)
        |-> ##[1:4] !dev_oe)
        else $error("device drive outlives read strobe");
    a_serial_quiet: assert property (!parallel_sel [*4] |-> !dev_oe)
        else $error("device drives in serial mode");
    // ==========
    // host drive
    a_wr_pulse: assert property (!bus_family_sel && parallel_sel &&
        $fell(write_strobe) |-> !write_strobe [*8] ##1 write_strobe)
        else $error("write strobe width wrong");
    a_wr_hold: assert property (!bus_family_sel && !write_strobe &&
        !$past(write_strobe) |-> $stable(host_d) && host_oe)
        else $error("write data moved under strobe");
    a_setup_sel: assert property (parallel_sel && !bus_family_sel &&
        $fell(write_strobe) |-> $past(sel, 3))
        else $error("strobe without select setup");
    a_en_pulse: assert property (bus_family_sel && sel && $rose(read_strobe)
        |-> read_strobe [*8] ##1 !read_strobe)
        else $error("enable pulse width wrong");
    a_serial_low: assert property (!parallel_sel && sel && host_oe
        |-> host_d[5:0] == 6'h00)
        else $error("unused serial lines not fixed");
    a_rd_no_host: assert property (parallel_sel && !bus_family_sel && !read_strobe
        |-> !host_oe)
        else $error("host drives during read");
endmodule

`default_nettype wire

/* File: tb/lcdp_bench.sv */
// testbench: APB-driven host end joined to the device end
`default_nettype none

module lcdp_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import lcdp_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [6:0]  prow = 7'h00;
    logic [7:0]  pcol = 8'h00;
    logic        pix;
    logic [6:0]  duty;
    logic [2:0]  bias;
    logic        rev;
    logic [31:0] st;
    logic        perr;
    int          errors = 0;
    int          n_compared = 0;
    int          seed = 32'h2B91;
    int          mem [int];
    int          page = 0;
    int          col = 0;
    int          hold = 0;
    int          revm = 0;
    logic [7:0]  rb;

    lcdp_if lcdp_if_i ();
    lcdp_host lcdp_host_i (.MCLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .BUS(lcdp_if_i.host));
    lcdp_dev lcdp_dev_i (.MCLK_I(clk), .SYS_RST_I(rst), .BUS(lcdp_if_i.dev),
        .PIX_ROW_I(prow), .PIX_COL_I(pcol), .PIX_O(pix), .DUTY_ROWS_O(duty),
        .BIAS_SEL_O(bias), .REVERSE_O(rev));
    lcdp_asserts lcdp_asserts_i (.MCLK_I(clk), .SYS_RST_I(rst),
        .select_low_n(lcdp_if_i.select_low_n), .select_high(lcdp_if_i.select_high),
        .read_strobe(lcdp_if_i.read_strobe), .write_strobe(lcdp_if_i.write_strobe),
        .bus_family_sel(lcdp_if_i.bus_family_sel), .parallel_sel(lcdp_if_i.parallel_sel),
        .host_d(lcdp_if_i.host_d), .host_oe(lcdp_if_i.host_oe), .dev_oe(lcdp_if_i.dev_oe));

    always #10 clk = ~clk;

    // ==========
    // shared tasks
    task automatic complete_run;
        if (errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        st = prdata;
        perr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // poll is bounded so a stuck busy flag shows as a mismatch, not a hang
    task automatic xfer(input logic cd, input logic rd, input logic [7:0] b);
        apb(1'b1, REG_CTRL, {22'h0, rd, cd, b});
        for (int i = 0; i < 100; i++) begin
            apb(1'b0, REG_STAT, 32'h0);
            if (st[STAT_BUSY_BIT] === 1'b0) break;
        end
        chk("busy", 32'h0, st[STAT_BUSY_BIT]);
    endtask
    task automatic setad(input int p, input int c);
        xfer(1'b0, 1'b0, 8'hB0 | p[7:0]);
        page = p;
        xfer(1'b0, 1'b0, 8'h10 | c[7:4]);
        xfer(1'b0, 1'b0, {4'h0, c[3:0]});
        col = c;
    endtask
    task automatic rdd(input bit cmp);
        xfer(1'b1, 1'b1, 8'h00);
        if (cmp) chk("read byte", hold, st[7:0]);
        hold = mem[page * 132 + col];
        if (col < 131) col++;
    endtask
    task automatic pchk(input int p, input int c, input int k);
        @(posedge clk);
        prow <= 7'(p * 8 + k);
        pcol <= 8'(c);
        repeat (3) @(posedge clk);
        chk("pixel", ((mem[p * 132 + c] >> k) & 1) ^ revm, pix);
    endtask

    // ==========
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, REG_CFG, 32'h0);
        chk("cfg reset", 32'h0A, st);
        repeat (2) @(posedge clk);
        chk("duty reset", DUTY_65, duty);
        apb(1'b0, 8'hFC, 32'h0);
        chk("unmapped err", 32'h1, perr);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, REG_CFG, 32'h02 | (i << 2));
            repeat (5) @(posedge clk);
            chk("duty", i[1] ? DUTY_65 : (i[0] ? DUTY_49 : DUTY_33), duty);
        end
        // modes: split strobes, enable clock, serial
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, REG_CFG, m == 0 ? 32'h02 : (m == 1 ? 32'h03 : 32'h00));
            setad(m, 130);
            for (int j = 0; j < 3; j++) begin
                rb = 8'($random(seed));
                xfer(1'b1, 1'b0, rb);
                mem[page * 132 + col] = rb;
                if (col < 131) col++;
            end
            pchk(m, 130, $unsigned($random(seed)) % 8);
            pchk(m, 131, $unsigned($random(seed)) % 8);
            if (m < 2) begin
                setad(m, 130);
                rdd(1'b0);
                rdd(1'b1);
                rdd(1'b1);
            end else begin
                xfer(1'b1, 1'b1, 8'h00);
                chk("serial read refused", 32'h1, st[STAT_REF_BIT]);
            end
        end
        apb(1'b1, REG_CFG, 32'h02);
        xfer(1'b0, 1'b1, 8'h00);
        chk("status", 32'h00, st[7:0]);
        xfer(1'b0, 1'b0, CMD_REVERSE);
        revm = 1;
        xfer(1'b0, 1'b1, 8'h00);
        chk("status rev", 32'h20, st[7:0]);
        chk("rev", 32'h1, rev);
        pchk(0, 131, 3);
        for (int b = 0; b < 6; b++) begin
            xfer(1'b0, 1'b0, 8'h30 | b[7:0]);
            chk("bias", b, bias);
        end
        apb(1'b1, REG_CFG, 32'h12);
        repeat (5) @(posedge clk);
        chk("init bias", BIAS_RST, bias);
        chk("init rev", 32'h0, rev);
        apb(1'b1, REG_CFG, 32'h02);
        complete_run;
    end

    initial begin
        #800000;
        errors++;
        complete_run;
    end
endmodule

`default_nettype wire
